/* trace_pkg.sv */
package trace_pkg;
  // ***************************************************
  // sizes
  // ***************************************************
  localparam int NCH = 8;            // capture channels
  localparam int DEPTH = 2048;       // entries per channel
  localparam int DW = 64;            // widest entry
  localparam int NSRC = 16;          // selectable internal sources
  localparam int AW = 11;            // entry index width
  localparam int CW = 16;            // window counter width
  localparam int MW = 8;             // period multiple width
  // ***************************************************
  // timing
  // ***************************************************
  localparam longint CLK_PERIOD_NS = 40;         // pclk period
  localparam longint BASE_TICK_NS = 62500;       // base sampling period
  localparam int BASE_TICK_CYC = int'(BASE_TICK_NS / CLK_PERIOD_NS);
  localparam longint MAX_REC_NS = 64'd20470000000; // longest recording
  localparam int MAX_MULT = int'(MAX_REC_NS / (BASE_TICK_NS * DEPTH));
  localparam int TIMEBASE_DIV = 10;  // recording = 10 x time base
  localparam int PCT = 100;          // percent scale of delay
  localparam int DELAY_MIN = -100;   // least trigger delay, percent
  localparam int DELAY_MAX = 400;    // largest trigger delay, percent
  // ***************************************************
  // register offsets
  // ***************************************************
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_PERIOD = 12'h004;
  localparam logic [11:0] OFS_TRIG_LO = 12'h008;
  localparam logic [11:0] OFS_TRIG_HI = 12'h00C;
  localparam logic [11:0] OFS_DELAY = 12'h010;
  localparam logic [11:0] OFS_STATUS = 12'h014;
  localparam logic [11:0] OFS_IRQ_STAT = 12'h018;
  localparam logic [11:0] OFS_IRQ_MASK = 12'h01C;
  localparam logic [11:0] OFS_RD_SEL = 12'h020;
  localparam logic [11:0] OFS_RD_LO = 12'h024;
  localparam logic [11:0] OFS_RD_HI = 12'h028;
  localparam logic [11:0] OFS_TIMEBASE = 12'h02C;
  localparam logic [11:0] OFS_CHCFG = 12'h040; // + 4 per channel
  // ***************************************************
  // fields and reset values
  // ***************************************************
  localparam int CTRL_START = 0;     // write 1: start
  localparam int CTRL_STOP = 1;      // write 1: abort
  localparam int CTRL_IMM = 2;       // immediate trigger
  localparam int CTRL_TCH = 4;       // trigger channel, 3 bits
  localparam int CTRL_FALL = 8;      // falling edge trigger
  localparam int CH_EN = 0;          // channel on
  localparam int CH_WID = 4;         // width code, 2 bits
  localparam int CH_SGN = 6;         // signed parameter
  localparam int CH_SRC = 8;         // source index, 4 bits
  localparam int RD_CH = 16;         // readout channel, 3 bits
  localparam int IRQ_DONE = 0;
  localparam int IRQ_TRIG = 1;
  localparam int IRQ_CFGERR = 2;
  localparam logic [MW-1:0] PERIOD_RST = 8'h01;
  localparam logic [2:0] MASK_RST = 3'h0;
  // ***************************************************
  // types
  // ***************************************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ARMED = 3'b001,
    ST_DELAY = 3'b010,
    ST_RECORD = 3'b011,
    ST_DONE = 3'b100
  } rec_state_t;
  typedef enum logic [1:0] {
    WID_8 = 2'b00,
    WID_16 = 2'b01,
    WID_32 = 2'b10,
    WID_64 = 2'b11
  } wid_t;
endpackage : trace_pkg

/* trace_tick.sv */
`timescale 1ns/100ps
module trace_tick
  import trace_pkg::*;
#(
  parameter int BASE_CYC = BASE_TICK_CYC
) (
  input wire logic pclk,           // clock
  input wire logic presetn,        // async reset, low
  input wire logic run,            // counting allowed
  input wire logic [MW-1:0] mult,  // period in base ticks
  output logic sample_en           // one-cycle sample pulse
);
  // ***************************************************
  // base tick and multiple divider
  // ***************************************************
  logic [15:0] base_r;   // cycles within base tick
  logic [MW-1:0] mul_r;  // base ticks within period

  // base divider and period multiple
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      base_r <= 16'h0000;
      mul_r <= 8'h00;
      sample_en <= 1'b0;
    end else if (!run) begin
      base_r <= 16'h0000;
      mul_r <= 8'h00;
      sample_en <= 1'b0;
    end else begin
      sample_en <= 1'b0;
      if (base_r == 16'(BASE_CYC - 1)) begin
        base_r <= 16'h0000;
        // period is whole base ticks only
        if (mul_r >= mult - 8'h01) begin
          mul_r <= 8'h00;
          sample_en <= 1'b1;
        end else begin
          mul_r <= mul_r + 8'h01;
        end
      end else begin
        base_r <= base_r + 16'h0001;
      end
    end
  end
endmodule : trace_tick

/* trace_recorder.sv */
`timescale 1ns/100ps
// How it works
// - one to eight channels, each one source
// - 2048 entries per channel per recording
// - entry width follows parameter, up to 64
// - period is whole multiples of base tick
// - shortest recording is full buffer, base period
// - longest recording up to 20.47 s, time base a tenth of it
// - recording lasts ten time bases
// - trigger source is any channel one..eight
// - threshold read in channel parameter's range
// - only recordable sources accepted
// - each config change checked, error flagged
// - data readable only after recording completes
// - start snapshots enabled channels only
// - immediate trigger records at once
// - negative delay keeps pre-trigger samples
module trace_recorder
  import trace_pkg::*;
#(
  parameter int BASE_CYC = BASE_TICK_CYC     // cycles per base tick
) (
  input wire logic pclk,                     // bus clock
  input wire logic presetn,                  // async reset, low
  input wire logic psel,                     // apb select
  input wire logic penable,                  // apb enable
  input wire logic pwrite,                   // apb direction
  input wire logic [11:0] paddr,             // apb byte address
  input wire logic [31:0] pwdata,            // apb write data
  output logic [31:0] prdata,                // apb read data
  output logic pready,                       // apb ready
  output logic pslverr,                      // unmapped address
  input wire logic [NSRC*DW-1:0] src_data,   // internal parameters
  input wire logic [NSRC-1:0] src_recordable, // recordable_attribute
  output logic irq                           // level interrupt
);
  // ***************************************************
  // declarations
  // ***************************************************
  rec_state_t state_r;             // recorder state
  logic [8:0] ctrl_r;              // imm, trigger channel, edge
  logic [MW-1:0] period_r;         // period multiple
  logic [63:0] thr_r;              // trigger threshold
  logic [15:0] delay_r;            // signed delay, percent
  logic [2:0] stat_r;              // sticky events
  logic [2:0] mask_r;              // event mask
  logic [18:0] rdsel_r;            // readout channel and index
  logic [NCH-1:0] run_en_r;        // channels of this run
  logic [AW-1:0] wr_ptr_r;         // next entry to write
  logic [CW-1:0] cnt_r;            // samples left in phase
  logic [CW-1:0] fill_r;           // pre-trigger samples held
  logic ge_prev_r;                 // last sample >= threshold
  logic prev_ok_r;                 // a previous sample exists
  logic chk_r;                     // config changed last cycle
  logic start_r;                   // start requested last cycle
  logic cfg_err_r;                 // config invalid
  logic [15:0] chcfg [NCH];        // channel settings
  logic [DW-1:0] chan_val [NCH];   // width-limited samples
  logic [DW-1:0] rd_word [NCH];    // readout per channel
  logic [NCH-1:0] en_bits;         // enabled channels now
  logic [NCH-1:0] bad_src;         // non-recordable source
  logic wr_en;                     // apb write takes effect
  logic setup;                     // apb setup cycle
  logic addr_ok;                   // address is mapped
  logic sample_en;                 // sample tick
  logic store;                     // write this sample
  logic cfg_bad;                   // config check result
  logic ge_now;                    // trigger sample >= threshold
  logic trig_hit;                  // trigger edge seen
  logic [CW-1:0] pre_n;            // samples before trigger
  logic [CW-1:0] post_n;           // samples after trigger
  logic [CW-1:0] wait_n;           // samples of positive delay
  logic [31:0] rd_mux;             // register read value
  logic [AW-1:0] rd_idx;           // memory index to read
  logic [2:0] set_ev;              // events this cycle
  logic [2:0] tch;                 // trigger channel
  logic [31:0] dur_ticks;          // duration in base ticks
  int dly;                         // delay as integer

  // sign or zero extend by width code
  function automatic logic [63:0] ext(input logic [63:0] v,
                                      input logic [1:0] w, input logic s);
    logic [63:0] r;
    r = v;
    case (w)
      WID_8: r = {{56{s & v[7]}}, v[7:0]};
      WID_16: r = {{48{s & v[15]}}, v[15:0]};
      WID_32: r = {{32{s & v[31]}}, v[31:0]};
      default: r = v;
    endcase
    return r;
  endfunction : ext

  // ***************************************************
  // per-channel source, memory and config
  // ***************************************************
  assign tch = ctrl_r[CTRL_TCH +: 3];
  assign store = sample_en & ((state_r == ST_ARMED) | (state_r == ST_RECORD));
  assign rd_idx = wr_ptr_r + rdsel_r[AW-1:0]; // oldest entry first

  for (genvar g = 0; g < NCH; g++) begin : g_ch
    logic [DW-1:0] mem_r [DEPTH];  // measurement memory
    logic [15:0] cfg_r;            // channel settings
    logic [3:0] src;               // selected source
    assign src = cfg_r[CH_SRC +: 4];
    assign chcfg[g] = cfg_r;
    assign en_bits[g] = cfg_r[CH_EN];
    // one source per channel, width from its type
    assign chan_val[g] = ext(src_data[src*DW +: DW], cfg_r[CH_WID +: 2],
                             cfg_r[CH_SGN]);
    assign bad_src[g] = cfg_r[CH_EN] & ~src_recordable[src];
    assign rd_word[g] = mem_r[rd_idx];

    // channel setting register
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cfg_r <= 16'h0000;
      end else if (wr_en && paddr == OFS_CHCFG + 12'(4 * g)) begin
        cfg_r <= pwdata[15:0];
      end
    end

    // only channels of this run are stored
    always_ff @(posedge pclk) begin
      if (store && run_en_r[g]) begin
        mem_r[wr_ptr_r] <= chan_val[g];
      end
    end
  end

  // ***************************************************
  // configuration check and window sizes
  // ***************************************************
  always_comb begin
    dly = int'($signed(delay_r));
    cfg_bad = (en_bits == '0) | (|bad_src);
    if (period_r == '0 || int'(period_r) > MAX_MULT) begin
      cfg_bad = 1'b1;
    end
    if (dly < DELAY_MIN || dly > DELAY_MAX) begin
      cfg_bad = 1'b1;
    end
    if (!ctrl_r[CTRL_IMM] && !en_bits[tch]) begin
      cfg_bad = 1'b1;
    end
    pre_n = '0;
    wait_n = '0;
    if (dly < 0) begin
      pre_n = CW'((-dly) * DEPTH / PCT);
    end else begin
      wait_n = CW'(dly * DEPTH / PCT);
    end
    post_n = CW'(DEPTH) - pre_n;
    dur_ticks = 32'(period_r) * 32'(DEPTH);
  end

  // ***************************************************
  // trigger detection
  // ***************************************************
  always_comb begin
    logic [63:0] a;
    logic [63:0] b;
    a = chan_val[tch];
    b = ext(thr_r, chcfg[tch][CH_WID +: 2], chcfg[tch][CH_SGN]);
    // threshold in channel's value range
    ge_now = chcfg[tch][CH_SGN] ? ($signed(a) >= $signed(b)) : (a >= b);
    trig_hit = prev_ok_r & (fill_r >= pre_n) &
               (ctrl_r[CTRL_FALL] ? (ge_prev_r & ~ge_now) : (~ge_prev_r & ge_now));
  end

  // ***************************************************
  // sample timer
  // ***************************************************
  trace_tick #(
    .BASE_CYC(BASE_CYC)
  ) u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .run((state_r == ST_ARMED) | (state_r == ST_DELAY) | (state_r == ST_RECORD)),
    .mult(period_r),
    .sample_en(sample_en)
  );

  // ***************************************************
  // apb slave
  // ***************************************************
  assign setup = psel & ~penable;
  assign wr_en = psel & penable & pwrite & pready;
  assign addr_ok = (paddr <= OFS_TIMEBASE) | (paddr[11:5] == OFS_CHCFG[11:5]);

  // settings written by software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= '0;
      period_r <= PERIOD_RST;
      thr_r <= '0;
      delay_r <= '0;
      mask_r <= MASK_RST;
      rdsel_r <= '0;
    end else if (wr_en) begin
      case (paddr)
        OFS_CTRL: ctrl_r <= {pwdata[8:4], 1'b0, pwdata[2:0]} & 9'h1F4;
        OFS_PERIOD: period_r <= pwdata[MW-1:0];
        OFS_TRIG_LO: thr_r[31:0] <= pwdata;
        OFS_TRIG_HI: thr_r[63:32] <= pwdata;
        OFS_DELAY: delay_r <= pwdata[15:0];
        OFS_IRQ_MASK: mask_r <= pwdata[2:0];
        OFS_RD_SEL: rdsel_r <= pwdata[18:0];
        default: ;
      endcase
    end
  end

  // change detect and start request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chk_r <= 1'b0;
      start_r <= 1'b0;
    end else begin
      chk_r <= wr_en & ((paddr <= OFS_DELAY) | (paddr[11:5] == OFS_CHCFG[11:5]));
      start_r <= wr_en & (paddr == OFS_CTRL) & pwdata[CTRL_START];
    end
  end

  // register read mux
  always_comb begin
    rd_mux = 32'h00000000;
    case (paddr)
      OFS_CTRL: rd_mux = {23'h0, ctrl_r};
      OFS_PERIOD: rd_mux = {24'h0, period_r};
      OFS_TRIG_LO: rd_mux = thr_r[31:0];
      OFS_TRIG_HI: rd_mux = thr_r[63:32];
      OFS_DELAY: rd_mux = {16'h0, delay_r};
      OFS_STATUS: rd_mux = {16'h0, run_en_r, 4'h0, cfg_err_r, state_r};
      OFS_IRQ_STAT: rd_mux = {29'h0, stat_r};
      OFS_IRQ_MASK: rd_mux = {29'h0, mask_r};
      OFS_RD_SEL: rd_mux = {13'h0, rdsel_r};
      // buffer visible only after completion
      OFS_RD_LO: rd_mux = (state_r == ST_DONE) ? rd_word[rdsel_r[RD_CH +: 3]][31:0]
                                               : 32'h00000000;
      OFS_RD_HI: rd_mux = (state_r == ST_DONE) ? rd_word[rdsel_r[RD_CH +: 3]][63:32]
                                               : 32'h00000000;
      OFS_TIMEBASE: rd_mux = dur_ticks / 32'(TIMEBASE_DIV);
      default: begin
        if (paddr[11:5] == OFS_CHCFG[11:5]) begin
          rd_mux = {16'h0, chcfg[paddr[4:2]]};
        end
      end
    endcase
  end

  // answer in first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= setup;
      pslverr <= setup & ~addr_ok;
      if (setup && !pwrite) begin
        prdata <= addr_ok ? rd_mux : 32'h00000000;
      end
    end
  end

  // ***************************************************
  // recording sequencer
  // ***************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_IDLE;
      run_en_r <= '0;
      wr_ptr_r <= '0;
      cnt_r <= '0;
      fill_r <= '0;
      ge_prev_r <= 1'b0;
      prev_ok_r <= 1'b0;
    end else if (wr_en && paddr == OFS_CTRL && pwdata[CTRL_STOP]) begin
      state_r <= ST_IDLE; // abort
    end else if (start_r && !cfg_bad &&
                 (state_r == ST_IDLE || state_r == ST_DONE)) begin
      run_en_r <= en_bits;
      wr_ptr_r <= '0;
      fill_r <= '0;
      prev_ok_r <= 1'b0;
      if (ctrl_r[CTRL_IMM]) begin
        state_r <= ST_RECORD; // no trigger
        cnt_r <= CW'(DEPTH);
      end else begin
        state_r <= ST_ARMED;
      end
    end else if (sample_en) begin
      case (state_r)
        ST_ARMED: begin
          // sample continuously before trigger
          wr_ptr_r <= wr_ptr_r + 1'b1;
          ge_prev_r <= ge_now;
          prev_ok_r <= 1'b1;
          if (fill_r < pre_n) begin
            fill_r <= fill_r + 1'b1;
          end
          if (trig_hit) begin
            if (wait_n != '0) begin
              state_r <= ST_DELAY;
              cnt_r <= wait_n;
            end else if (post_n == '0) begin
              state_r <= ST_DONE;
            end else begin
              state_r <= ST_RECORD;
              cnt_r <= post_n;
            end
          end
        end
        ST_DELAY: begin
          cnt_r <= cnt_r - 1'b1;
          if (cnt_r == CW'(1)) begin
            state_r <= ST_RECORD;
            cnt_r <= CW'(DEPTH);
          end
        end
        ST_RECORD: begin
          wr_ptr_r <= wr_ptr_r + 1'b1;
          cnt_r <= cnt_r - 1'b1;
          if (cnt_r == CW'(1)) begin
            state_r <= ST_DONE;
          end
        end
        default: ;
      endcase
    end
  end

  // ***************************************************
  // config error and interrupts
  // ***************************************************
  // check on every change
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_err_r <= 1'b0;
    end else if (chk_r) begin
      cfg_err_r <= cfg_bad;
    end
  end

  always_comb begin
    set_ev = 3'h0;
    set_ev[IRQ_DONE] = sample_en & (((state_r == ST_RECORD) & (cnt_r == CW'(1))) |
                                    ((state_r == ST_ARMED) & trig_hit &
                                     (wait_n == '0) & (post_n == '0)));
    set_ev[IRQ_TRIG] = sample_en & (state_r == ST_ARMED) & trig_hit;
    // bad config after a change, or refused start: bad config or recorder busy
    set_ev[IRQ_CFGERR] = (chk_r & cfg_bad) | (start_r & (cfg_bad |
                         ~((state_r == ST_IDLE) | (state_r == ST_DONE))));
  end

  // sticky status, set beats clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_r <= 3'h0;
      irq <= 1'b0;
    end else begin
      if (wr_en && paddr == OFS_IRQ_STAT) begin
        stat_r <= (stat_r & ~pwdata[2:0]) | set_ev;
      end else begin
        stat_r <= stat_r | set_ev;
      end
      irq <= |(stat_r & mask_r);
    end
  end
endmodule : trace_recorder

/* param_source.sv */
`timescale 1ns/100ps
// ****
// ramping internal parameters
// ****
module param_source
  import trace_pkg::*;
(
  input wire logic pclk,               // clock
  input wire logic presetn,            // reset, low
  output logic [NSRC*DW-1:0] src_data  // parameter values
);
  logic [15:0] ramp_r; // shared ramp
  // ramp wraps every 4096 pclk cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ramp_r <= 16'h0000;
    else ramp_r <= ramp_r + 16'h0010;
  end
  // source k sits k above the ramp
  always_comb begin
    for (int k = 0; k < NSRC; k++) src_data[k*DW+:DW] = {48'h0, ramp_r + 16'(k)};
  end
endmodule : param_source

/* trace_recorder_assertions.sv */
`timescale 1ns/100ps
// ****
// port checker
// ****
module trace_checker
  import trace_pkg::*;
(
  input wire logic pclk,          // clock
  input wire logic presetn,       // reset, low
  input wire logic psel,          // select
  input wire logic penable,       // enable
  input wire logic pwrite,        // direction
  input wire logic [11:0] paddr,  // address
  input wire logic [31:0] pwdata, // write data
  input wire logic [31:0] prdata, // read data
  input wire logic pready,        // ready
  input wire logic pslverr,       // error
  input wire logic irq            // interrupt
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // mapped word addresses
  function automatic logic mapped(input logic [11:0] a);
    return a[1:0] == 2'b00 && (a <= 12'h02C || (a >= 12'h040 && a <= 12'h05C));
  endfunction
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_done;
    psel && penable && pready;
  endsequence
  a_ready_next: assert property (s_setup |=> pready)
    else $error("no ready after setup");
  a_ready_once: assert property (pready |=> !pready)
    else $error("ready too long");
  a_ready_cause: assert property (pready |-> $past(psel && !penable))
    else $error("ready without setup");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_unmapped_err: assert property (s_setup ##0 !mapped(paddr) |=> pslverr)
    else $error("unmapped not refused");
  a_mapped_ok: assert property (s_setup ##0 mapped(paddr) |=> !pslverr)
    else $error("mapped refused");
  a_err_zero: assert property (s_done ##0 (pslverr && !pwrite) |-> prdata == 32'h0)
    else $error("refused read not zero");
  a_data_hold: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
    else $error("read data moved");
  a_ctrl_pulse: assert property (s_done ##0 (!pwrite && paddr == OFS_CTRL)
    |-> prdata[1:0] == 2'b00)
    else $error("start or stop reads one");
  a_mask_quiet: assert property (s_done ##0 (pwrite && paddr == OFS_IRQ_MASK
    && pwdata[2:0] == 3'h0) |-> ##2 !irq)
    else $error("irq with mask clear");
endmodule : trace_checker
bind trace_recorder trace_checker chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .irq(irq));

/* multichannel_trace_recorder_tb.sv */
`timescale 1ns/100ps
// ****
// recorder bench
// ****
module multichannel_trace_recorder_tb;
  import trace_pkg::*;
  typedef struct {logic [31:0] d; logic [31:0] m; logic e;} note_t;
  logic pclk = 1'b0;              // clock
  logic presetn = 1'b0;           // reset, low
  logic psel = 1'b0;              // select
  logic penable = 1'b0;           // enable
  logic pwrite = 1'b0;            // direction
  logic [11:0] paddr = 12'h000;   // address
  logic [31:0] pwdata = 32'h0;    // write data
  logic [31:0] prdata;            // read data
  logic [31:0] rd;                // last read
  logic pready;                   // ready
  logic pslverr;                  // error
  logic irq;                      // interrupt
  logic [NSRC*DW-1:0] src_data;   // parameters
  logic [NSRC-1:0] src_recordable = 16'h0000; // recordable_attribute
  int n_fail = 0;
  int n_compared = 0;
  int seed = 92;
  note_t notes[$];                // expected answers
  logic [11:0] ta [10] = '{OFS_PERIOD, OFS_PERIOD, OFS_PERIOD, OFS_DELAY, OFS_DELAY,
    OFS_DELAY, OFS_DELAY, OFS_DELAY, OFS_CHCFG + 12'h00C, OFS_CHCFG + 12'h00C};
  logic [31:0] tv [10] = '{32'h0, 32'hA0, 32'h1, 32'hFF9B, 32'hFF9C, 32'h190, 32'h191,
    32'h0, 32'h311, 32'h0};
  logic [9:0] tbad = 10'b0101001011; // invalid marks
  initial begin
    forever #20 pclk = ~pclk;
  end
  trace_recorder #(.BASE_CYC(4)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .src_data(src_data), .src_recordable(src_recordable), .irq(irq));
  param_source src_u (.pclk(pclk), .presetn(presetn), .src_data(src_data));
  task complete_run;
    $display("n_fail=%0d n_compared=%0d", n_fail, n_compared);
    if (n_fail == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : complete_run
  task fail(input string s);
    n_fail++;
    $display("[FAIL] %0t %s", $time, s);
  endtask : fail
  task cmp_read(input note_t n, input logic [31:0] q, input logic e);
    n_compared++;
    if (((q & n.m) !== (n.d & n.m)) || e !== n.e) fail($sformatf("read %h exp %h", q, n.d));
  endtask : cmp_read
  task cmp_irq(input logic x);
    n_compared++;
    if (irq !== x) fail("irq level");
  endtask : cmp_irq
  // one apb transfer, note first
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] x,
      input logic [31:0] m, output logic [31:0] q);
    note_t n;
    n.d = x;
    n.m = m;
    n.e = !(a <= 12'h02C || (a >= 12'h040 && a <= 12'h05C));
    notes.push_back(n);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h0, 32'h0, rd);
  endtask : wr
  task rdc(input logic [11:0] a, input logic [31:0] x, input logic [31:0] m);
    apb(1'b0, a, 32'h0, x, m, rd);
  endtask : rdc
  // poll state, bounded
  task wait_st(input logic [2:0] s);
    for (int i = 0; i < 80; i++) begin
      rdc(OFS_STATUS, 32'h0, 32'h0);
      if (rd[2:0] === s) break;
      repeat (500) @(posedge pclk);
    end
  endtask : wait_st
  // answer monitor
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      if (notes.size() == 0) fail("answer without note");
      else cmp_read(notes.pop_front(), prdata, pslverr);
    end
  end
  // watchdog
  initial begin
    repeat (90000) @(posedge pclk);
    fail("timeout");
    complete_run();
  end
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rdc(OFS_CTRL, 32'h0, 32'hFFFFFFFF);
    rdc(OFS_PERIOD, 32'h1, 32'hFF);
    rdc(OFS_IRQ_MASK, 32'h0, 32'h7);
    rdc(OFS_STATUS, 32'h0, 32'hFF07);
    rdc(OFS_TIMEBASE, DEPTH / TIMEBASE_DIV, 32'hFFFFFFFF);
    rdc(OFS_RD_LO, 32'h0, 32'hFFFFFFFF);
    wr(12'h030, $random(seed));
    rdc(12'h060, 32'h0, 32'hFFFFFFFF);
    wr(OFS_PERIOD, 32'h1);
    rdc(OFS_STATUS, 32'h8, 32'h8);
    rdc(OFS_IRQ_STAT, 32'h4, 32'h4);
    cmp_irq(1'b0);
    wr(OFS_IRQ_MASK, 32'h4);
    repeat (2) @(posedge pclk);
    cmp_irq(1'b1);
    wr(OFS_IRQ_STAT, 32'h4);
    repeat (2) @(posedge pclk);
    cmp_irq(1'b0);
    src_recordable <= (16'($random(seed)) | 16'h0024) & ~16'h0008;
    wr(OFS_CHCFG, 32'h211);
    wr(OFS_CHCFG + 12'h014, 32'h531);
    wr(OFS_CTRL, 32'h4);
    rdc(OFS_STATUS, 32'h0, 32'h8);
    for (int i = 0; i < 10; i++) begin
      wr(ta[i], tv[i]);
      rdc(OFS_STATUS, {28'h0, tbad[i], 3'h0}, 32'h8);
    end
    wr(OFS_PERIOD, 32'd159);
    rdc(OFS_TIMEBASE, 159 * DEPTH / TIMEBASE_DIV, 32'hFFFFFFFF);
    wr(OFS_PERIOD, 32'h1);
    wr(OFS_IRQ_STAT, 32'h7);
    wr(OFS_CTRL, 32'h5);
    rdc(OFS_STATUS, 32'h2103, 32'hFF07);
    wr(OFS_CTRL, 32'h5);
    rdc(OFS_IRQ_STAT, 32'h4, 32'h4);
    rdc(OFS_STATUS, 32'h3, 32'h7);
    rdc(OFS_RD_HI, 32'h0, 32'hFFFFFFFF);
    wr(OFS_CTRL, 32'h2);
    rdc(OFS_STATUS, 32'h0, 32'h7);
    wr(OFS_CHCFG + 12'h014, 32'h0);
    wr(OFS_TRIG_LO, 32'h8000);
    wr(OFS_TRIG_HI, 32'h0);
    wr(OFS_DELAY, 32'hFFFF);
    wr(OFS_CTRL, 32'h0);
    wr(OFS_CTRL, 32'h1);
    rdc(OFS_STATUS, 32'h0101, 32'hFF07);
    repeat (40) @(posedge pclk);
    rdc(OFS_STATUS, 32'h1, 32'h7);
    wait_st(3'h3);
    rdc(OFS_STATUS, 32'h3, 32'h7);
    rdc(OFS_IRQ_STAT, 32'h2, 32'h2);
    wr(OFS_CTRL, 32'h2);
    wr(OFS_DELAY, 32'h0);
    wr(OFS_CTRL, 32'h1);
    wait_st(3'h3);
    rdc(OFS_STATUS, 32'h3, 32'h7);
    wait_st(3'h4);
    rdc(OFS_STATUS, 32'h4, 32'h7);
    rdc(OFS_IRQ_STAT, 32'h1, 32'h1);
    wr(OFS_IRQ_MASK, 32'h0);
    repeat (3) @(posedge pclk);
    complete_run();
  end
endmodule : multichannel_trace_recorder_tb
